// ==== rtl/crab_top.sv ====
// CPU bus to byte-wide boot ROM bridge with APB registers
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - Decode top 2M of the 4G space as boot ROM window.
// - 512K ROM mirrors every 512K throughout that window.
// - ROM is byte wide on shared AD lines, never a PCI target.
// - Read does eight byte cycles, no frame, then both acknowledges.
// - Burst reads get the same 8-byte group on every beat.
// - ROM enabled only during the bridge's own ROM cycles.
// - Hardware reset puts endian logic in big-endian mode.
// - Locked write completes normally, not forwarded, sets status bit 0.
// - Flash data writes use FFFF_FFF0 with address and data encoded.
// - Write data swapper is gated by endian mode; address ignored.
// - Any write to FFFF_FFF1 locks ROM writes until reset.
module crab_top
  import crab_pkg::*;
#(
  parameter int RD_WAIT = RD_WAIT_CYC,
  parameter int WE_WAIT = WE_CYC
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  // CPU bus side
  input wire logic cpu_ts,
  input wire logic [31:0] cpu_addr,
  input wire logic cpu_write,
  input wire logic cpu_burst,
  input wire logic [3:0] cpu_size,
  input wire logic [63:0] cpu_wdata,
  output logic rom_hit,
  output logic address_acknowledge_n,
  output logic transfer_acknowledge_n,
  output logic [63:0] cpu_rdata,
  // Shared AD lines and ROM controls
  input wire logic [31:0] ad_in,
  output logic [31:0] ad_out,
  output logic ad_oe,
  output logic rom_ce_n,
  output logic rom_oe_n,
  output logic rom_we_n
);
  crab_state_e state_q;
  logic [15:0] wait_q;
  logic [2:0] byte_idx_q;
  logic [2:0] beats_q;
  logic address_acknowledge_n_done_q;
  logic [ROM_AW-1:0] rom_off_q;
  logic burst_q;
  logic [31:0] wr_word_q;
  logic le_q;
  logic lock_q;
  logic [7:0] err_q;
  logic [7:0] mask_q;
  logic [31:0] ad_s1_q;
  logic [31:0] ad_s2_q;
  logic [63:0] swapped;
  logic take;
  logic is_lock_wr;
  logic is_data_wr;
  logic locked_wr_evt;
  logic gather_load;
  logic gather_clr;
  logic apb_wr;
  logic [9:0] reg_idx;
  logic reg_hit;

  // True when the CPU address falls in the top 2M
  function automatic logic in_window(input logic [31:0] a);
    return a[31:21] == WIN_TAG;
  endfunction : in_window

  // window decode
  // Qualifies the CPU request; other addresses belong to other targets
  assign rom_hit = cpu_ts && in_window(cpu_addr);
  assign take = rom_hit && state_q[0];
  assign is_lock_wr = cpu_write && (cpu_addr == FLASH_LOCK_ADDR);
  // single data write address
  // Low three address bits ignored so an LE-munged address still hits
  assign is_data_wr = cpu_write && !is_lock_wr &&
                      (cpu_addr[31:3] == FLASH_WR_ADDR[31:3]);
  assign locked_wr_evt = take && cpu_write && !is_lock_wr && lock_q;

  // data swapper gated by endian mode
  crab_swap #(
    .NBYTES(BYTES_PER_READ)
  ) u_swap (
    .le_mode(le_q),
    .din(cpu_wdata),
    .dout(swapped)
  );

  // AD pin inputs cross two flops before anything reads them
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ad_s1_q <= '0;
      ad_s2_q <= '0;
    end
    else
    begin
      ad_s1_q <= ad_in;
      ad_s2_q <= ad_s1_q;
    end
  end

  // ascending bytes gathered MSB lane first
  // RD_WAIT under 4 samples byte 0 before it clears the synchroniser
  assign gather_clr = take && !cpu_write;
  assign gather_load = state_q[1] && (wait_q == 16'(RD_WAIT - 1));
  crab_byte_gather #(
    .NBYTES(BYTES_PER_READ)
  ) u_gather (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .clr(gather_clr),
    .load(gather_load),
    .byte_in(ad_s2_q[7:0]),
    .group_q(cpu_rdata)
  );

  // Bridge sequencer
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q <= ST_IDLE;
      wait_q <= '0;
      byte_idx_q <= '0;
      beats_q <= '0;
      address_acknowledge_n_done_q <= 1'b0;
      rom_off_q <= '0;
      burst_q <= 1'b0;
      wr_word_q <= '0;
    end
    else
    begin
      unique case (state_q)
        ST_IDLE:
        begin
          wait_q <= '0;
          byte_idx_q <= '0;
          address_acknowledge_n_done_q <= 1'b0;
          if (take)
          begin
            // mirror by dropping upper window bits
            rom_off_q <= {cpu_addr[ROM_AW-1:3], 3'h0};
            burst_q <= cpu_burst && !cpu_write;
            // Upper word carries lanes 0-3 after the swapper
            wr_word_q <= swapped[63:32];
            if (!cpu_write)
              state_q <= ST_RD;
            else if (is_data_wr && !lock_q)
              state_q <= ST_WR;
            else
              state_q <= ST_ACK; // completes without ROM cycle
            beats_q <= (cpu_burst && !cpu_write) ? BURST_BEATS : 3'h1;
          end
        end
        ST_RD:
        begin
          if (gather_load)
          begin
            wait_q <= '0;
            byte_idx_q <= byte_idx_q + 3'h1;
            if (byte_idx_q == 3'(BYTES_PER_READ - 1))
              state_q <= ST_ACK;
          end
          else
            wait_q <= wait_q + 16'h1;
        end
        ST_WR:
        begin
          // One extra cycle holds data after the strobe rises
          if (wait_q == 16'(WE_WAIT))
          begin
            wait_q <= '0;
            state_q <= ST_ACK;
          end
          else
            wait_q <= wait_q + 16'h1;
        end
        // every beat repeats the gathered group
        ST_ACK:
        begin
          address_acknowledge_n_done_q <= 1'b1;
          beats_q <= beats_q - 3'h1;
          if (beats_q == 3'h1)
            state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Address acknowledge once, transfer acknowledge each beat
  assign address_acknowledge_n = !(state_q[3] && !address_acknowledge_n_done_q);
  assign transfer_acknowledge_n = !state_q[3];

  // ROM and AD drive only during own cycles
  // no frame; ROM strobed by its own controls
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ad_out <= '0;
      ad_oe <= 1'b0;
      rom_ce_n <= 1'b1;
      rom_oe_n <= 1'b1;
      rom_we_n <= 1'b1;
    end
    else if (state_q[1] && !(gather_load &&
             byte_idx_q == 3'(BYTES_PER_READ - 1)))
    begin
      // Next byte address goes out as the previous one is sampled
      ad_out <= 32'({rom_off_q[ROM_AW-1:3],
                     gather_load ? byte_idx_q + 3'h1 : byte_idx_q});
      ad_oe <= 1'b1;
      rom_ce_n <= 1'b0;
      rom_oe_n <= 1'b0;
      rom_we_n <= 1'b1;
    end
    else if (state_q[2] && wait_q != 16'(WE_WAIT))
    begin
      // Encoded word carries flash address and data together
      ad_out <= wr_word_q;
      ad_oe <= 1'b1;
      rom_ce_n <= 1'b0;
      rom_oe_n <= 1'b1;
      rom_we_n <= !(wait_q < 16'(WE_WAIT - 1));
    end
    else
    begin
      ad_out <= '0;
      ad_oe <= 1'b0;
      rom_ce_n <= 1'b1;
      rom_oe_n <= 1'b1;
      rom_we_n <= 1'b1;
    end
  end

  // lock sets once, only reset clears it
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      lock_q <= 1'b0;
    else if (take && is_lock_wr)
      lock_q <= 1'b1;
  end

  // APB decode; slave answers in the first access cycle
  assign reg_idx = paddr[11:2];
  assign reg_hit = (reg_idx == IDX_CTRL) || (reg_idx == IDX_ERR_STAT2) ||
                   (reg_idx == IDX_IRQ_MASK);
  assign apb_wr = psel && penable && pwrite && reg_hit;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !reg_hit;

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      le_q <= CTRL_LE_RST;
      mask_q <= MASK_RST;
    end
    else if (apb_wr)
    begin
      if (reg_idx == IDX_CTRL)
        le_q <= pwdata[CTRL_LE_BIT];
      if (reg_idx == IDX_IRQ_MASK)
        mask_q <= pwdata[7:0];
    end
  end

  // sticky violation flag, set wins over write-one clear
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      err_q <= '0;
    else
    begin
      if (apb_wr && reg_idx == IDX_ERR_STAT2)
        err_q[ERR_LOCKED_WR_BIT] <= err_q[ERR_LOCKED_WR_BIT] &
                                    !pwdata[ERR_LOCKED_WR_BIT];
      if (locked_wr_evt)
        err_q[ERR_LOCKED_WR_BIT] <= 1'b1;
    end
  end

  // Level interrupt while any unmasked status bit is set
  assign irq = |(err_q & mask_q);

  // Read mux; reserved bits read zero
  always_comb
  begin
    prdata = '0;
    if (psel)
    begin
      if (reg_idx == IDX_CTRL)
      begin
        prdata[CTRL_LE_BIT] = le_q;
        prdata[CTRL_LOCK_BIT] = lock_q;
      end
      else if (reg_idx == IDX_ERR_STAT2)
        prdata[7:0] = err_q;
      else if (reg_idx == IDX_IRQ_MASK)
        prdata[7:0] = mask_q;
    end
  end
endmodule : crab_top
`default_nettype wire

// ==== common/crab_pkg.sv ====
// Shared constants for the CPU-to-ROM access bridge
package crab_pkg;
  // CPU address decode
  localparam logic [10:0] WIN_TAG = 11'h7ff; // addr[31:21], top 2M
  localparam int ROM_AW = 19; // 512K ROM
  localparam logic [31:0] FLASH_WR_ADDR = 32'hffff_fff0;
  localparam logic [31:0] FLASH_LOCK_ADDR = 32'hffff_fff1;
  localparam logic [31:0] BOOT_FETCH_ADDR = 32'hfff0_0100;
  localparam int BYTES_PER_READ = 8;
  localparam logic [2:0] BURST_BEATS = 3'h4;
  // Encoded flash write word layout
  localparam int ENC_DATA_LSB = 0;
  localparam int ENC_ADDR_LSB = 8;
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int ROM_ACCESS_NS = 120;
  localparam int ROM_WE_NS = 50;
  localparam int SYNC_STAGES = 2;
  // Least times round up; sync stages add to the read wait
  localparam int RD_WAIT_CYC =
    (ROM_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES;
  localparam int WE_CYC = (ROM_WE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_CTRL = 10'h0c0;
  localparam logic [9:0] IDX_ERR_STAT2 = 10'h0c5;
  localparam logic [9:0] IDX_IRQ_MASK = 10'h0c6;
  // Field positions
  localparam int CTRL_LE_BIT = 0;
  localparam int CTRL_LOCK_BIT = 1;
  localparam int ERR_LOCKED_WR_BIT = 0;
  // Reset values
  localparam logic CTRL_LE_RST = 1'b0; // big-endian
  localparam logic [7:0] MASK_RST = 8'h00;
  // Bridge sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_RD = 4'b0010,
    ST_WR = 4'b0100,
    ST_ACK = 4'b1000
  } crab_state_e;
endpackage : crab_pkg

// ==== rtl/crab_byte_gather.sv ====
// Collects ROM bytes into one 8-byte group
`timescale 1ns/100ps
`default_nettype none
module crab_byte_gather #(
  parameter int NBYTES = 8
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clr,
  input wire logic load,
  input wire logic [7:0] byte_in,
  output logic [NBYTES*8-1:0] group_q
);
  // Shift left so the first (lowest address) byte ends on the MSB lane
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      group_q <= '0;
    else if (clr)
      group_q <= '0;
    else if (load)
      group_q <= {group_q[NBYTES*8-9:0], byte_in};
  end
endmodule : crab_byte_gather
`default_nettype wire

// ==== rtl/crab_swap.sv ====
// Endian-gated byte lane swapper
`timescale 1ns/100ps
`default_nettype none
module crab_swap #(
  parameter int NBYTES = 8
) (
  input wire logic le_mode,
  input wire logic [NBYTES*8-1:0] din,
  output logic [NBYTES*8-1:0] dout
);
  // Lane i swaps with lane NBYTES-1-i only in little-endian mode
  always_comb
  begin
    dout = din;
    if (le_mode)
      for (int i = 0; i < NBYTES; i++)
        dout[i*8 +: 8] = din[(NBYTES-1-i)*8 +: 8];
  end
endmodule : crab_swap
`default_nettype wire

// ==== dv/crab_rom_model.sv ====
// Byte-wide flash model on the shared AD lines
`timescale 1ns/100ps
`default_nettype none
module crab_rom_model (
  input wire logic sys_clk,
  input wire logic [31:0] ad_out,
  input wire logic rom_ce_n,
  input wire logic rom_oe_n,
  input wire logic rom_we_n,
  output logic [31:0] ad_in,
  output logic [31:0] wr_word,
  output int wr_cnt
);
  logic [31:0] last_q = 32'h0;
  logic rd_en;
  assign rd_en = !rom_ce_n && !rom_oe_n;
  // one byte on low lane; idle lines flip so stale data fails
  assign ad_in = rd_en ? {24'h0, ad_out[7:0] ^ 8'ha5} : ~last_q;
  // Last driven value
  always @(posedge sys_clk)
    if (rd_en)
      last_q <= ad_in;
  // flash latches the word as the strobe ends
  always @(posedge rom_we_n)
  begin
    wr_word = ad_out;
    wr_cnt++;
  end
endmodule : crab_rom_model
`default_nettype wire

// ==== dv/crab_chk.sv ====
// Port checker for the ROM bridge
`timescale 1ns/100ps
`default_nettype none
module crab_chk
  import crab_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic cpu_ts,
  input wire logic [31:0] cpu_addr,
  input wire logic cpu_write,
  input wire logic cpu_burst,
  input wire logic rom_hit,
  input wire logic address_acknowledge_n,
  input wire logic transfer_acknowledge_n,
  input wire logic [63:0] cpu_rdata,
  input wire logic ad_oe,
  input wire logic rom_ce_n,
  input wire logic rom_oe_n,
  input wire logic rom_we_n
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  logic lock_q;
  // Lock write seen on the bus, kept to reset
  always_ff @(posedge sys_clk or negedge arst_n)
    if (!arst_n)
      lock_q <= 1'b0;
    else if (cpu_ts && cpu_write && !address_acknowledge_n &&
             cpu_addr == FLASH_LOCK_ADDR)
      lock_q <= 1'b1;
  sequence four_beats;
    !transfer_acknowledge_n [*4] ##1 transfer_acknowledge_n;
  endsequence
  win_decode_a: assert property (rom_hit == (cpu_ts && cpu_addr[31:21] == WIN_TAG))
    else $error("rom window decode wrong");
  ce_own_a: assert property (!rom_ce_n |-> ad_oe)
    else $error("rom selected outside bridge cycle");
  strobe_sel_a: assert property ((!rom_oe_n || !rom_we_n) |-> !rom_ce_n)
    else $error("rom strobe without select");
  address_acknowledge_n_pulse_a: assert property (!address_acknowledge_n |=> address_acknowledge_n)
    else $error("address acknowledge too long");
  ack_pair_a: assert property (!address_acknowledge_n |-> !transfer_acknowledge_n)
    else $error("address acknowledge without transfer");
  burst_beats_a: assert property (!address_acknowledge_n && cpu_burst && !cpu_write |-> four_beats)
    else $error("burst beat count wrong");
  beat_same_a: assert property (!transfer_acknowledge_n ##1 !transfer_acknowledge_n |-> $stable(cpu_rdata))
    else $error("read data changed within burst");
  lock_block_a: assert property (lock_q |-> rom_we_n)
    else $error("rom written after lock");
endmodule : crab_chk
bind crab_top crab_chk u_chk (.sys_clk, .arst_n, .cpu_ts, .cpu_addr,
  .cpu_write, .cpu_burst, .rom_hit, .address_acknowledge_n,
  .transfer_acknowledge_n, .cpu_rdata, .ad_oe, .rom_ce_n, .rom_oe_n,
  .rom_we_n);
`default_nettype wire

// ==== dv/crab_bench.sv ====
// Self-checking bench for the ROM bridge
`timescale 1ns/100ps
`default_nettype none
module crab_bench
  import crab_pkg::*;
;
  logic sys_clk, arst_n, psel, penable, pwrite, pready, pslverr, irq, e;
  logic cpu_ts, cpu_write, cpu_burst, rom_hit, ad_oe;
  logic address_acknowledge_n, transfer_acknowledge_n;
  logic rom_ce_n, rom_oe_n, rom_we_n;
  logic [3:0] cpu_size;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, cpu_addr, ad_in, ad_out, wr_word, r32;
  logic [63:0] cpu_wdata, cpu_rdata, r64;
  int n_mismatch, checked, cyc, wc, wr_cnt;
  crab_top #(.RD_WAIT(4), .WE_WAIT(2)) dut (.sys_clk, .arst_n, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq,
    .cpu_ts, .cpu_addr, .cpu_write, .cpu_burst, .cpu_size, .cpu_wdata,
    .rom_hit, .address_acknowledge_n, .transfer_acknowledge_n, .cpu_rdata,
    .ad_in, .ad_out, .ad_oe, .rom_ce_n, .rom_oe_n, .rom_we_n);
  crab_rom_model rom (.sys_clk, .ad_out, .rom_ce_n, .rom_oe_n, .rom_we_n,
    .ad_in, .wr_word, .wr_cnt);
  // Free-running clock
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic results();
    if (n_mismatch == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results
  task automatic rst();
    arst_n <= 1'b0;
    repeat (10) @(posedge sys_clk);
    arst_n <= 1'b1;
  endtask : rst
  task automatic apb(input logic w, input logic [9:0] i,
                     input logic [31:0] d);
    @(posedge sys_clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, i, 2'b00, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    r32 = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic cpu(input logic [31:0] a, input logic w, input logic b,
                     input logic [63:0] d);
    @(posedge sys_clk);
    {cpu_ts, cpu_addr, cpu_write, cpu_burst, cpu_wdata} <= {1'b1, a, w, b, d};
    cpu_size <= w ? 4'h4 : 4'h8;
    do @(posedge sys_clk); while (address_acknowledge_n !== 1'b0);
    r64 = cpu_rdata;
    cpu_ts <= 1'b0;
    while (transfer_acknowledge_n !== 1'b1) @(posedge sys_clk);
  endtask : cpu
  // Expected group: ascending bytes, first on top lane
  function automatic logic [63:0] grp(input logic [31:0] a);
    logic [63:0] g;
    for (int i = 0; i < 8; i++)
      g[63-8*i -: 8] = {a[7:3], 3'(i)} ^ 8'ha5;
    return g;
  endfunction : grp
  // Hang guard
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      results();
    end
  end
  // Main sequence
  initial
  begin
    {psel, penable, pwrite, cpu_ts, cpu_write, cpu_burst} = 6'h00;
    {paddr, pwdata, cpu_addr, cpu_size, cpu_wdata} = '0;
    arst_n = 1'b0;
    rst();
    apb(0, IDX_CTRL, 32'h0);
    chk(r32, 32'h0);
    cpu(BOOT_FETCH_ADDR, 0, 0, 64'h0);
    chk(r64, grp(BOOT_FETCH_ADDR));
    for (int k = 0; k < 4; k++)
    begin
      cpu(32'hffe0_0048 + k * 32'h0008_0000, 0, k[0], 64'h0);
      chk(r64, grp(32'h0000_0048));
    end
    @(posedge sys_clk);
    {cpu_ts, cpu_addr} <= {1'b1, 32'hffdf_fff8};
    @(posedge sys_clk);
    chk(rom_hit, 1'b0);
    cpu_ts <= 1'b0;
    cpu(FLASH_WR_ADDR, 1, 0, {32'h0056_78c3, 32'h0});
    chk(wr_word, 32'h0056_78c3);
    apb(1, IDX_CTRL, 32'h3);
    cpu(FLASH_WR_ADDR, 1, 0, {32'h0, 32'h5a34_1200});
    chk(wr_word, 32'h0012_345a);
    apb(1, IDX_CTRL, 32'h0);
    cpu(FLASH_LOCK_ADDR, 1, 0, 64'h0);
    wc = wr_cnt;
    cpu(FLASH_WR_ADDR, 1, 0, {32'hdead_beef, 32'h0});
    chk(wr_cnt, wc);
    apb(0, IDX_ERR_STAT2, 32'h0);
    chk({r32[0], irq}, 2'b10);
    apb(1, IDX_IRQ_MASK, 32'h1);
    @(posedge sys_clk);
    chk(irq, 1'b1);
    apb(1, IDX_ERR_STAT2, 32'h1);
    @(posedge sys_clk);
    chk(irq, 1'b0);
    apb(0, IDX_CTRL, 32'h0);
    chk(r32, 32'h2);
    apb(0, 10'h001, 32'h0);
    chk({e, r32}, {1'b1, 32'h0});
    rst();
    apb(0, IDX_CTRL, 32'h0);
    chk(r32, 32'h0);
    cpu(FLASH_WR_ADDR, 1, 0, {32'h0000_0011, 32'h0});
    chk(wr_cnt, wc + 1);
    chk(wr_word, 32'h0000_0011);
    results();
  end
endmodule : crab_bench
`default_nettype wire
